// File: hdl/nand_host_pkg.sv
// constants for the host controller that sequences a nand flash part over its pins
package nand_host_pkg;

   // ------------------------------------------------------------
   // register byte offsets on the avalon slave
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_CONFIG = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_GUARD  = 4'hc;

   // ctrl fields: byte in [7:0], operation in [10:8]
   localparam int CTRL_BYTE_LSB = 0;
   localparam int CTRL_OP_LSB   = 8;
   // config fields
   localparam int CFG_WP_BIT    = 0;
   localparam int CFG_GATE_BIT  = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   // status fields
   localparam int STS_BUSY_BIT  = 0;
   localparam int STS_RB_BIT    = 1;
   localparam int STS_REF_BIT   = 2;
   localparam int STS_DATA_LSB  = 8;
   // guard fields: block in [9:0], enable in bit 16
   localparam int GUARD_EN_BIT  = 16;

   // ------------------------------------------------------------
   // operations requested through ctrl
   // ------------------------------------------------------------
   localparam logic [2:0] OP_CMD      = 3'h0;
   localparam logic [2:0] OP_ADDR     = 3'h1;
   localparam logic [2:0] OP_DIN      = 3'h2;
   localparam logic [2:0] OP_DOUT     = 3'h3;
   localparam logic [2:0] OP_WAIT     = 3'h4;
   localparam logic [2:0] OP_DESELECT = 3'h5;

   // ------------------------------------------------------------
   // command codes of the flash
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_READ_LO  = 8'h00;
   localparam logic [7:0] CMD_READ_HI  = 8'h01;
   localparam logic [7:0] CMD_PROGRAM  = 8'h10;
   localparam logic [7:0] CMD_SPARE    = 8'h50;
   localparam logic [7:0] CMD_ERASE    = 8'h60;
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_CONFIRM  = 8'hd0;
   localparam logic [7:0] CMD_RESET    = 8'hff;
   localparam logic [1:0] PROG_LIMIT   = 2'h2;

   // ------------------------------------------------------------
   // pin timing at a 4 ns clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int T_WP_NS       = 25;   // write strobe low
   localparam int T_HIGH_NS     = 25;   // strobe high, covers 50 ns cycle
   localparam int T_REA_NS      = 35;   // read_access_delay
   localparam int T_WB_NS       = 100;  // write high to busy
   localparam int SYNC_STAGES   = 2;

   // least time in ns to whole cycles, never below one
   function automatic logic [4:0] ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (c < 1) begin
         c = 1;
      end
      return c[4:0];
   endfunction : ns_to_cyc

   localparam logic [4:0] WP_CYC   = ns_to_cyc(T_WP_NS);
   localparam logic [4:0] HIGH_CYC = ns_to_cyc(T_HIGH_NS);
   localparam logic [4:0] RE_CYC   = ns_to_cyc(T_REA_NS) + 5'(SYNC_STAGES + 1);
   localparam logic [4:0] WB_CYC   = ns_to_cyc(T_WB_NS);

   typedef enum logic [2:0] {
      ST_IDLE, ST_WLOW, ST_RLOW, ST_HIGH, ST_WB, ST_READY
   } seq_state_type;

endpackage : nand_host_pkg

// File: hdl/nand_host_ctrl.sv
// host controller that drives a nand flash through its pins under avalon-mm control
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module nand_host_ctrl (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             cle,
   output logic             ale,
   output logic             chip_select_n,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             spare_region_gate_n,
   output logic             write_protect_n,
   output logic      [7:0]  io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_in
);

   // ------------------------------------------------------------
   // synchronisers for pins from the flash
   // ------------------------------------------------------------
   logic [7:0] io_s1_q, io_s2_q;
   logic       rb_s1_q, rb_s2_q;

   // two flops on the data bus and on ready/busy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         io_s1_q <= 8'h00;
         io_s2_q <= 8'h00;
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end else begin
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
         rb_s1_q <= ready_busy_in;   // released line reads high via pull-up
         rb_s2_q <= rb_s1_q;
      end
   end

   // ------------------------------------------------------------
   // controller state
   // ------------------------------------------------------------
   nand_host_pkg::seq_state_type state_q, state_d;
   logic [4:0]  cnt_q, cnt_d;
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  cfg_q, cfg_d;
   logic [10:0] guard_q, guard_d;
   logic        refused_q, refused_d;
   logic [7:0]  rbyte_q, rbyte_d;
   logic [7:0]  last_cmd_q, last_cmd_d;
   logic [1:0]  addr_idx_q, addr_idx_d;
   logic [13:0] row_q, row_d, prog_row_q, prog_row_d;
   logic [1:0]  prog_cnt_q, prog_cnt_d;
   logic        cle_q, cle_d, ale_q, ale_d, cs_n_q, cs_n_d;
   logic        we_n_q, we_n_d, re_n_q, re_n_d;
   logic [7:0]  io_q, io_d;
   logic        oe_q, oe_d;

   logic       acc, wr_ctrl, reject;
   logic [7:0] wbyte;
   logic [2:0] wop;
   logic       guard_hit;

   // bus decode, refusal checks and the pin sequencer
   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      rdata_d    = rdata_q;
      cfg_d      = cfg_q;
      guard_d    = guard_q;
      refused_d  = refused_q;
      rbyte_d    = rbyte_q;
      last_cmd_d = last_cmd_q;
      addr_idx_d = addr_idx_q;
      row_d      = row_q;
      prog_row_d = prog_row_q;
      prog_cnt_d = prog_cnt_q;
      cle_d      = cle_q;
      ale_d      = ale_q;
      cs_n_d     = cs_n_q;
      we_n_d     = we_n_q;
      re_n_d     = re_n_q;
      io_d       = io_q;
      oe_d       = oe_q;
      // one wait cycle, then a single ready cycle per access
      wait_d  = !((avs_read || avs_write) && wait_q);
      acc     = !wait_q && (avs_read || avs_write);
      wbyte   = avs_writedata[nand_host_pkg::CTRL_BYTE_LSB +: 8];
      wop     = avs_writedata[nand_host_pkg::CTRL_OP_LSB +: 3];
      wr_ctrl = acc && avs_write && (avs_address == nand_host_pkg::OFS_CTRL);
      // block zero is never fenced off by the guard
      guard_hit = guard_q[nand_host_pkg::GUARD_EN_BIT - 6] && (row_q[13:4] == guard_q[9:0])
                  && (row_q[13:4] != 10'h000);
      reject = 1'b0;
      if (state_q != nand_host_pkg::ST_IDLE) begin
         reject = 1'b1;
      end else if (wop == nand_host_pkg::OP_CMD) begin
         if (!rb_s2_q && (wbyte != nand_host_pkg::CMD_STATUS)
             && (wbyte != nand_host_pkg::CMD_RESET)) begin
            reject = 1'b1;   // flash still busy
         end
         if ((wbyte == nand_host_pkg::CMD_SPARE) && cfg_q[nand_host_pkg::CFG_GATE_BIT]) begin
            reject = 1'b1;   // spare read needs gate low
         end
         if (((wbyte == nand_host_pkg::CMD_PROGRAM) || (wbyte == nand_host_pkg::CMD_CONFIRM))
             && guard_hit) begin
            reject = 1'b1;   // marked-bad block
         end
         if ((wbyte == nand_host_pkg::CMD_PROGRAM) && (row_q == prog_row_q)
             && (prog_cnt_q == nand_host_pkg::PROG_LIMIT)) begin
            reject = 1'b1;   // partial program limit
         end
      end
      // register writes
      if (acc && avs_write) begin
         unique case (avs_address)
            nand_host_pkg::OFS_CONFIG: cfg_d = avs_writedata[1:0];
            nand_host_pkg::OFS_GUARD: guard_d = {avs_writedata[nand_host_pkg::GUARD_EN_BIT],
                                                 avs_writedata[9:0]};
            nand_host_pkg::OFS_STATUS: begin
               if (avs_writedata[nand_host_pkg::STS_REF_BIT]) begin
                  refused_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // register reads, unmapped offsets read zero
      if (avs_read && wait_q) begin
         rdata_d = 32'h0000_0000;
         unique case (avs_address)
            nand_host_pkg::OFS_CONFIG: rdata_d[1:0] = cfg_q;
            nand_host_pkg::OFS_GUARD: rdata_d = {15'h0000, guard_q[10], 6'h00, guard_q[9:0]};
            nand_host_pkg::OFS_STATUS: begin
               rdata_d[nand_host_pkg::STS_BUSY_BIT] = (state_q != nand_host_pkg::ST_IDLE);
               rdata_d[nand_host_pkg::STS_RB_BIT] = rb_s2_q;
               rdata_d[nand_host_pkg::STS_REF_BIT] = refused_q;
               rdata_d[nand_host_pkg::STS_DATA_LSB +: 8] = rbyte_q;
            end
            default: ;
         endcase
      end
      // start an accepted operation
      if (wr_ctrl && !reject) begin
         cnt_d = nand_host_pkg::WP_CYC;
         unique case (wop)
            nand_host_pkg::OP_CMD, nand_host_pkg::OP_ADDR, nand_host_pkg::OP_DIN: begin
               cs_n_d = 1'b0;                                   // select the part
               cle_d  = (wop == nand_host_pkg::OP_CMD);
               ale_d  = (wop == nand_host_pkg::OP_ADDR);
               we_n_d = 1'b0;                                   // latches low for data
               io_d   = wbyte;
               oe_d   = 1'b1;
               state_d = nand_host_pkg::ST_WLOW;
            end
            nand_host_pkg::OP_DOUT: begin
               cs_n_d = 1'b0;
               cle_d  = 1'b0;
               ale_d  = 1'b0;
               oe_d   = 1'b0;                                   // flash drives the bus
               re_n_d = 1'b0;                                   // one read toggle per byte
               cnt_d  = nand_host_pkg::RE_CYC;
               state_d = nand_host_pkg::ST_RLOW;
            end
            nand_host_pkg::OP_WAIT: begin
               cnt_d = nand_host_pkg::WB_CYC;
               state_d = nand_host_pkg::ST_WB;
            end
            nand_host_pkg::OP_DESELECT: begin
               cs_n_d = 1'b1;                                   // abandons a read
               cle_d  = 1'b0;
               ale_d  = 1'b0;
            end
            default: ;
         endcase
         // track the command and address cycles
         if (wop == nand_host_pkg::OP_CMD) begin
            last_cmd_d = wbyte;
            addr_idx_d = 2'h0;
            if (wbyte == nand_host_pkg::CMD_CONFIRM) begin
               prog_cnt_d = 2'h0;                               // erase resets the count
            end
            if (wbyte == nand_host_pkg::CMD_PROGRAM) begin
               prog_row_d = row_q;
               prog_cnt_d = (row_q == prog_row_q) ? prog_cnt_q + 2'h1 : 2'h1;
            end
         end
         if (wop == nand_host_pkg::OP_ADDR) begin
            // erase skips the column cycle
            if (last_cmd_q == nand_host_pkg::CMD_ERASE) begin
               if (addr_idx_q == 2'h0) begin
                  row_d[7:0] = wbyte;
               end else if (addr_idx_q == 2'h1) begin
                  row_d[13:8] = wbyte[5:0];
               end
            end else begin
               if (addr_idx_q == 2'h1) begin
                  row_d[7:0] = wbyte;
               end else if (addr_idx_q == 2'h2) begin
                  row_d[13:8] = wbyte[5:0];
               end
            end
            if (addr_idx_q != 2'h3) begin
               addr_idx_d = addr_idx_q + 2'h1;
            end
         end
      end
      if (wr_ctrl && reject) begin
         refused_d = 1'b1;   // a new refusal beats a clear
      end
      // pin sequencer
      unique case (state_q)
         nand_host_pkg::ST_IDLE: ;
         nand_host_pkg::ST_WLOW: begin
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               we_n_d = 1'b1;                                   // latching edge
               cnt_d = nand_host_pkg::HIGH_CYC;
               state_d = nand_host_pkg::ST_HIGH;
            end
         end
         nand_host_pkg::ST_RLOW: begin
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               rbyte_d = io_s2_q;
               re_n_d = 1'b1;
               cnt_d = nand_host_pkg::HIGH_CYC;
               state_d = nand_host_pkg::ST_HIGH;
            end
         end
         nand_host_pkg::ST_HIGH: begin
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               cle_d = 1'b0;
               ale_d = 1'b0;
               oe_d = 1'b0;
               state_d = nand_host_pkg::ST_IDLE;
            end
         end
         nand_host_pkg::ST_WB: begin
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               state_d = nand_host_pkg::ST_READY;
            end
         end
         nand_host_pkg::ST_READY: begin
            if (rb_s2_q) begin
               state_d = nand_host_pkg::ST_IDLE;             // ready again
            end
         end
      endcase
   end

   // register every piece of controller state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q    <= nand_host_pkg::ST_IDLE;
         cnt_q      <= 5'h00;
         wait_q     <= 1'b1;
         rdata_q    <= 32'h0000_0000;
         cfg_q      <= nand_host_pkg::CFG_RESET;
         guard_q    <= 11'h000;
         refused_q  <= 1'b0;
         rbyte_q    <= 8'h00;
         last_cmd_q <= 8'h00;
         addr_idx_q <= 2'h0;
         row_q      <= 14'h0000;
         prog_row_q <= 14'h0000;
         prog_cnt_q <= 2'h0;
         cle_q      <= 1'b0;
         ale_q      <= 1'b0;
         cs_n_q     <= 1'b1;
         we_n_q     <= 1'b1;
         re_n_q     <= 1'b1;
         io_q       <= 8'h00;
         oe_q       <= 1'b0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         cfg_q      <= cfg_d;
         guard_q    <= guard_d;
         refused_q  <= refused_d;
         rbyte_q    <= rbyte_d;
         last_cmd_q <= last_cmd_d;
         addr_idx_q <= addr_idx_d;
         row_q      <= row_d;
         prog_row_q <= prog_row_d;
         prog_cnt_q <= prog_cnt_d;
         cle_q      <= cle_d;
         ale_q      <= ale_d;
         cs_n_q     <= cs_n_d;
         we_n_q     <= we_n_d;
         re_n_q     <= re_n_d;
         io_q       <= io_d;
         oe_q       <= oe_d;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // ------------------------------------------------------------
   assign avs_readdata        = rdata_q;
   assign avs_waitrequest     = wait_q;
   assign cle                 = cle_q;
   assign ale                 = ale_q;
   assign chip_select_n       = cs_n_q;
   assign write_strobe_n      = we_n_q;
   assign read_strobe_n       = re_n_q;
   assign spare_region_gate_n = cfg_q[nand_host_pkg::CFG_GATE_BIT];
   assign write_protect_n     = cfg_q[nand_host_pkg::CFG_WP_BIT];
   assign io_out              = io_q;
   assign io_oe               = oe_q;

endmodule : nand_host_ctrl

// File: bench/nand_host_ctrl_sva.sv
// concurrent checks on the nand host controller ports
`timescale 1ns/1ps
module nand_host_ctrl_sva (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [3:0] avs_address,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       chip_select_n,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic       spare_region_gate_n,
   input wire logic       write_protect_n,
   input wire logic [7:0] io_out,
   input wire logic       io_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // slave answers after one wait cycle and holds the answer one cycle
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // pin relations of the strobes and latches
   a_latch_excl: assert property (!(cle && ale))
      else $error("command and address latch high together");
   a_strobe_excl: assert property (!(!write_strobe_n && !read_strobe_n))
      else $error("write and read strobe low together");
   a_write_select: assert property (!write_strobe_n |-> !chip_select_n && io_oe)
      else $error("write strobe without chip select or bus drive");
   a_we_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*7] ##1 write_strobe_n)
      else $error("write strobe low pulse not seven cycles");
   a_we_gap: assert property ($rose(write_strobe_n) |-> write_strobe_n [*7])
      else $error("write strobe high phase shorter than seven cycles");
   a_latch_hold: assert property ($rose(write_strobe_n) |-> $stable(io_out) && $stable({cle, ale}) && io_oe)
      else $error("byte or latch changed at write strobe rise");
   a_read_mode: assert property (!read_strobe_n |-> !cle && !ale && !chip_select_n && !io_oe)
      else $error("read strobe low with wrong pin state");
   a_spare_gate: assert property ($rose(write_strobe_n) && cle && io_out == nand_host_pkg::CMD_SPARE
      |-> !spare_region_gate_n)
      else $error("spare read command sent with gate high");
   a_cfg_source: assert property ($changed({spare_region_gate_n, write_protect_n})
      |-> $past(avs_write && !avs_waitrequest && avs_address == nand_host_pkg::OFS_CONFIG))
      else $error("gate or protect pin moved without a config write");
endmodule : nand_host_ctrl_sva

bind nand_host_ctrl nand_host_ctrl_sva u_sva (
   .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .cle(cle), .ale(ale), .chip_select_n(chip_select_n),
   .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .spare_region_gate_n(spare_region_gate_n),
   .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe)
);

// File: bench/flash_model.sv
// behavioural nand flash device on the far side of the host controller pins
`timescale 1ns/1ps
module flash_model #(
   parameter int BUSY_NS           = 2000,
   parameter int READ_NS           = 400,
   parameter int read_access_delay = 35
) (
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       chip_select_n,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       spare_region_gate_n,
   input  wire logic       write_protect_n,
   input  wire logic [7:0] io_bus,
   output logic      [7:0] io_dev,
   output logic            busy_pull
);
   logic [7:0] page [0:527];
   logic [7:0] cmd       = 8'h00;
   logic [7:0] last      = 8'h00;
   int         col       = 0;
   int         acnt      = 0;
   int         prog_cnt  = 0;
   int         erase_cnt = 0;

   initial begin
      busy_pull = 1'b0;
      io_dev = 8'hff;
   end

   // column step; gate high keeps the sixteen spare bytes out
   function automatic int next_col(input int c);
      return (c + 1) % (spare_region_gate_n ? 512 : 528);
   endfunction : next_col

   // pull the open-drain line low, whatever chip select does meanwhile
   task automatic go_busy(input int ns);
      busy_pull = 1'b1;
      #(ns);
      busy_pull = 1'b0;
   endtask : go_busy

   // latch command, address or data at the write strobe rise
   always @(posedge write_strobe_n) begin
      if (!chip_select_n && (!busy_pull || io_bus == 8'h70 || io_bus == 8'hff)) begin
         if (cle) begin
            cmd = io_bus;
            acnt = 0;
            if ((io_bus == 8'h10 || io_bus == 8'hd0) && write_protect_n) begin
               if (io_bus == 8'h10) prog_cnt++;
               else erase_cnt++;
               fork go_busy(BUSY_NS); join_none
            end
         end else if (ale) begin
            if (acnt == 0) begin
               col = (cmd == 8'h01) ? 256 + io_bus : (cmd == 8'h50) ? 512 + io_bus[3:0] : io_bus;
            end
            acnt++;
            if (acnt == 3 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)) begin
               fork go_busy(READ_NS); join_none
            end
         end else begin
            page[col] = io_bus;
            col = next_col(col);
         end
      end
   end

   // next byte valid after the access delay, column steps by one
   always @(negedge read_strobe_n) begin
      if (!chip_select_n) begin
         io_dev = ~last;
         #(read_access_delay) last = page[col];
         io_dev = last;
         col = next_col(col);
      end
   end

   // released bus shows the inverse of the last byte
   always @(posedge read_strobe_n or posedge chip_select_n) begin
      #15 io_dev = ~last;
   end
endmodule : flash_model

// File: bench/testbench.sv
// self-checking bench for the nand host controller against a flash model
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        cle, ale, chip_select_n, write_strobe_n, read_strobe_n;
   logic        spare_region_gate_n, write_protect_n, io_oe, busy_pull;
   logic [7:0]  io_out, io_dev, io_bus;
   int          err_count = 0;
   int          cmp_count = 0;

   // host drive wins while enabled; ready line has a pull-up
   assign io_bus = io_oe ? io_out : io_dev;

   nand_host_ctrl u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cle(cle), .ale(ale), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .spare_region_gate_n(spare_region_gate_n),
      .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .ready_busy_in(!busy_pull));
   flash_model u_flash (.cle(cle), .ale(ale), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .spare_region_gate_n(spare_region_gate_n), .write_protect_n(write_protect_n),
      .io_bus(io_bus), .io_dev(io_dev), .busy_pull(busy_pull));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one avalon access held until waitrequest is seen low; reads land in rd
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!wr) rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus

   // one sequencer operation, then poll until it is done
   task automatic op(input logic [2:0] o, input logic [7:0] b);
      bus(1'b1, nand_host_pkg::OFS_CTRL, {21'h0, o, b});
      rd = 32'h1;
      for (int i = 0; i < 2000 && rd[nand_host_pkg::STS_BUSY_BIT] !== 1'b0; i++) begin
         bus(1'b0, nand_host_pkg::OFS_STATUS, 32'h0);
      end
      chk({31'h0, rd[nand_host_pkg::STS_BUSY_BIT]}, 32'h0);
   endtask : op

   // compare the refusal flag, then clear it by writing a one
   task automatic flag(input logic e);
      bus(1'b0, nand_host_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, rd[nand_host_pkg::STS_REF_BIT]}, {31'h0, e});
      bus(1'b1, nand_host_pkg::OFS_STATUS, 32'h4);
   endtask : flag

   // page program of two bytes; while busy only the status or reset command may pass
   task automatic prog(input logic [7:0] row, input logic e);
      op(nand_host_pkg::OP_CMD, 8'h80);
      op(nand_host_pkg::OP_ADDR, 8'h00);
      op(nand_host_pkg::OP_ADDR, row);
      op(nand_host_pkg::OP_ADDR, 8'h00);
      op(nand_host_pkg::OP_DIN, 8'ha5);
      op(nand_host_pkg::OP_DIN, 8'h3c);
      op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_PROGRAM);
      flag(e);
      chk({31'h0, rd[nand_host_pkg::STS_RB_BIT]}, {31'h0, e});
      if (!e) begin
         op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_READ_LO);
         flag(1'b1);
         op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_STATUS);
         flag(1'b0);
      end
      op(nand_host_pkg::OP_WAIT, 8'h00);
   endtask : prog

   task automatic t_reset;
      chk({27'h0, cle, ale, chip_select_n, write_strobe_n, read_strobe_n}, 32'h7);
      chk({29'h0, io_oe, write_protect_n, spare_region_gate_n}, 32'h0);
      bus(1'b0, nand_host_pkg::OFS_CONFIG, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
   endtask : t_reset

   task automatic t_prog_read;
      bus(1'b1, nand_host_pkg::OFS_CONFIG, 32'h1);
      prog(8'h05, 1'b0);
      chk({16'h0, u_flash.page[0], u_flash.page[1]}, 32'ha53c);
      chk(32'(u_flash.prog_cnt), 32'h1);
      op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_READ_LO);
      for (int i = 0; i < 3; i++) op(nand_host_pkg::OP_ADDR, (i == 1) ? 8'h05 : 8'h00);
      op(nand_host_pkg::OP_WAIT, 8'h00);
      op(nand_host_pkg::OP_DOUT, 8'h00);
      chk({24'h0, rd[nand_host_pkg::STS_DATA_LSB +: 8]}, 32'ha5);
      op(nand_host_pkg::OP_DOUT, 8'h00);
      chk({24'h0, rd[nand_host_pkg::STS_DATA_LSB +: 8]}, 32'h3c);
      op(nand_host_pkg::OP_DESELECT, 8'h00);
      chk({31'h0, chip_select_n}, 32'h1);
   endtask : t_prog_read

   task automatic t_refuse;
      op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_SPARE);
      flag(1'b0);
      op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_READ_LO);
      bus(1'b1, nand_host_pkg::OFS_CONFIG, 32'h3);
      op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_SPARE);
      flag(1'b1);
      chk({24'h0, u_flash.cmd}, 32'h0);
      bus(1'b1, nand_host_pkg::OFS_CONFIG, 32'h1);
      prog(8'h05, 1'b0);
      prog(8'h05, 1'b1);
      chk(32'(u_flash.prog_cnt), 32'h2);
   endtask : t_refuse

   task automatic t_guard;
      bus(1'b1, nand_host_pkg::OFS_GUARD, 32'h10000);
      prog(8'h06, 1'b0);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, nand_host_pkg::OFS_GUARD, (i == 0) ? 32'h10001 : 32'h0);
         bus(1'b0, nand_host_pkg::OFS_GUARD, 32'h0);
         chk(rd, (i == 0) ? 32'h10001 : 32'h0);
         op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_ERASE);
         op(nand_host_pkg::OP_ADDR, 8'h10);
         op(nand_host_pkg::OP_ADDR, 8'h00);
         op(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_CONFIRM);
         flag(i == 0);
         op(nand_host_pkg::OP_WAIT, 8'h00);
      end
      chk(32'(u_flash.erase_cnt), 32'h1);
      bus(1'b1, nand_host_pkg::OFS_CONFIG, 32'h0);
      chk({31'h0, write_protect_n}, 32'h0);
   endtask : t_guard

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // watchdog far beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_prog_read();
      t_refuse();
      t_guard();
      report_and_stop();
   end
endmodule : testbench
